//--- sss_pkg.sv
// sss_pkg: constants, types and reset values of the servo speed supervisor
package sss_pkg;
	// clock and units
	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned MS_PER_TENTH = 100;
	localparam int unsigned MS_CYCLES    = CLK_HZ / 1000;
	localparam int unsigned TENTH_CYCLES = MS_CYCLES * MS_PER_TENTH;
	localparam int unsigned SPM_STEP     = 40;
	localparam int unsigned RPM_STEP     = 20;
	localparam int unsigned PWR_STEP_MS  = 4;
	localparam int unsigned FWD_STEPS    = 5;
	localparam int unsigned LAST_STITCH  = FWD_STEPS - 1;
	// register byte offsets
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_SLOW_A = 12'h004;
	localparam logic [11:0] OFS_SLOW_B = 12'h008;
	localparam logic [11:0] OFS_BND_A  = 12'h00C;
	localparam logic [11:0] OFS_BND_B  = 12'h010;
	localparam logic [11:0] OFS_PSPD_A = 12'h014;
	localparam logic [11:0] OFS_PSPD_B = 12'h018;
	localparam logic [11:0] OFS_LIMIT  = 12'h01C;
	localparam logic [11:0] OFS_TIMES  = 12'h020;
	localparam logic [11:0] OFS_PWROFF = 12'h024;
	localparam logic [11:0] OFS_THR    = 12'h028;
	localparam logic [11:0] OFS_SCALE  = 12'h02C;
	localparam logic [11:0] OFS_STAT   = 12'h030;
	localparam logic [11:0] OFS_MASK   = 12'h034;
	localparam logic [11:0] OFS_RUNST  = 12'h038;
	// status bit positions
	localparam int unsigned ST_SYNC = 0;
	localparam int unsigned ST_OVL  = 1;
	localparam int unsigned ST_PWR  = 2;
	localparam int unsigned ST_AB   = 3;
	localparam int unsigned ST_RSTB = 4;
	localparam int unsigned ST_REV  = 5;
	localparam int unsigned ST_SLOW = 6;
	localparam int unsigned ST_W    = 7;
	typedef logic [7:0] sss_code_t;
	typedef enum logic [1:0] {
		SS_IDLE = 2'b00,
		SS_SLOW = 2'b01,
		SS_RUN  = 2'b10
	} sss_state_e;
	// all programmable settings except the interrupt mask
	typedef struct packed {
		logic                slow_trim;
		logic                slow_stop;
		logic                spd_sel;
		logic [1:0]          scale;
		logic [4:0][7:0]     slow;
		logic [4:0][6:0]     bnd;
		logic [4:0][7:0]     pspd;
		logic [7:0]          max_rpm;
		logic [10:0]         sync_t;
		logic [10:0]         ovl_t;
		logic [7:0]          pwr;
		logic [7:0]          thr_ab;
		logic [7:0]          thr_rb;
		logic [7:0]          thr_rv;
		logic [7:0]          a2;
		logic [7:0]          updn;
	} sss_cfg_s;
	// synchronised pin group
	typedef struct packed {
		logic sync;
		logic sup_ok;
		logic a;
		logic b;
		logic r;
		logic s;
		logic t;
	} sss_pins_s;
	localparam logic [4:0][7:0] SLOW_DEF = {8'(1680 / SPM_STEP), 8'(1000 / SPM_STEP),
		8'(640 / SPM_STEP), 8'(400 / SPM_STEP), 8'(400 / SPM_STEP)};
	localparam logic [4:0][7:0] BUILTIN_SLOW = SLOW_DEF;
	localparam sss_cfg_s CFG_RST = '{
		slow_trim: 1'b0, slow_stop: 1'b0, spd_sel: 1'b0, scale: 2'h1,
		slow: SLOW_DEF,
		bnd: {7'h3B, 7'h2F, 7'h26, 7'h16, 7'h11},
		pspd: {8'(9960 / SPM_STEP), 8'(5480 / SPM_STEP), 8'(4000 / SPM_STEP),
			8'(920 / SPM_STEP), 8'(440 / SPM_STEP)},
		max_rpm: 8'(4000 / RPM_STEP), sync_t: 11'h028, ovl_t: 11'h01E,
		pwr: 8'(4 / PWR_STEP_MS), thr_ab: 8'h04, thr_rb: 8'h04, thr_rv: 8'h04,
		a2: 8'(4000 / SPM_STEP), updn: 8'(4000 / SPM_STEP)};
endpackage : sss_pkg

//--- sss_tmo.sv
// sss_tmo: tick-based watchdog that fires once when its wait runs past a limit
module sss_tmo
	import sss_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        en,
	input  wire logic        restart,
	input  wire logic        tick,
	input  wire logic [10:0] limit,
	output logic             expired
);
	logic [10:0] cnt_q;

	// fires on the tick that completes the limit
	assign expired = en && !restart && tick && (limit != 11'h000) && (cnt_q == 11'(limit - 11'h001));

	// counter cleared whenever the awaited event shows up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 11'h000;
		end else if (!en || restart) begin
			cnt_q <= 11'h000;
		end else if (tick && cnt_q != limit) begin
			cnt_q <= 11'(cnt_q + 11'h001);
		end
	end

	tmo_clear_a: assert property (@(posedge pclk) disable iff (!presetn) restart |=> cnt_q == 11'h000)
		else $error("watchdog count not cleared on its event");
endmodule : sss_tmo

//--- sss_evt_cnt.sv
// sss_evt_cnt: counts bad encoder detections and flags the threshold
module sss_evt_cnt
	import sss_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       evt,
	input  wire logic       clr,
	input  wire logic [7:0] thr,
	output logic            hit
);
	logic [7:0] cnt_q;

	// threshold reached by this detection
	assign hit = evt && (thr != 8'h00) && (cnt_q == 8'(thr - 8'h01));

	// saturating detection count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
		end else if (clr) begin
			cnt_q <= 8'h00;
		end else if (evt && cnt_q != 8'hFF) begin
			cnt_q <= 8'(cnt_q + 8'h01);
		end
	end

	cnt_hit_a: assert property (@(posedge pclk) disable iff (!presetn) hit && !clr |=> cnt_q == $past(thr))
		else $error("encoder fault flagged off threshold");
endmodule : sss_evt_cnt

//--- sss_supervisor.sv
// sss_supervisor: slow start, pedal curve, speed ceiling and motor supervision
module sss_supervisor
	import sss_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TENTH_CYCLES,
	parameter int unsigned MS_TICKS    = MS_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  pedal_level,
	input  wire logic        trim_done,
	input  wire logic [13:0] motor_rpm,
	input  wire sss_pins_s   pins,
	output logic [13:0]      speed_cmd,
	output logic             slow_active,
	output logic             irq
);
	sss_cfg_s        cfg_q;
	sss_state_e      state_q;
	sss_pins_s       meta_q, pin_q, prev_q;
	logic [2:0]      idx_q, step;
	logic [ST_W-1:0] stat_q, mask_q, ev, w1c;
	logic [13:0]     speed_cmd_q, cmd_d;
	logic [31:0]     prdata_q, rd_d;
	logic            pslverr_q, rd_err, armed_q, fault, wr_en;
	logic [23:0]     tick_cnt_q, ms_cnt_q;
	logic            tick, ms_tick, sync_rise;
	logic [7:0]      pedal_code, curve_code, slow_code, code;
	logic [2:0]      sec_now, sec_prev;
	logic            rst_chg, ab_bad, rst_bad, rst_rev;
	logic            sync_exp, ovl_exp, pwr_exp, hit_ab, hit_rb, hit_rv;

	// forward step reached by the quantised stroke
	function automatic logic [2:0] fwd_step(input logic [5:0] q, input logic [4:0][6:0] bnd);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < FWD_STEPS; i++) begin
			if ({1'b0, q} >= bnd[i]) begin
				n = 3'(i + 1);
			end
		end
		return n;
	endfunction : fwd_step

	// speed code to rpm command, limited by the ceiling
	function automatic logic [13:0] clamp_cmd(input logic [7:0] c, input logic [7:0] lim);
		logic [13:0] s, l;
		s = 14'(c) * 14'(SPM_STEP);
		l = 14'(lim) * 14'(RPM_STEP);
		return (s > l) ? l : s;
	endfunction : clamp_cmd

	// rescale a curve point so the top step lands on the target
	function automatic logic [7:0] scale(input logic [7:0] c, input logic [7:0] tgt, input logic [7:0] top);
		logic [15:0] p;
		p = 16'h0000;
		if (top == 8'h00) begin
			return c;
		end
		p = (16'(c) * 16'(tgt)) / 16'(top);
		return (p > 16'h00FF) ? 8'hFF : p[7:0];
	endfunction : scale

	// commutation sector, 7 for an illegal pattern
	function automatic logic [2:0] hall_sec(input logic [2:0] h);
		case (h)
			3'b001: return 3'h0;
			3'b011: return 3'h1;
			3'b010: return 3'h2;
			3'b110: return 3'h3;
			3'b100: return 3'h4;
			3'b101: return 3'h5;
			default: return 3'h7;
		endcase
	endfunction : hall_sec

	// two-stage synchroniser plus edge history for all pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			pin_q  <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pins;
			pin_q  <= meta_q;
			prev_q <= pin_q;
		end
	end

	// common periodic ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 24'h000000;
			ms_cnt_q   <= 24'h000000;
		end else begin
			tick_cnt_q <= tick ? 24'h000000 : 24'(tick_cnt_q + 24'h000001);
			ms_cnt_q   <= ms_tick ? 24'h000000 : 24'(ms_cnt_q + 24'h000001);
		end
	end
	assign tick    = (tick_cnt_q == 24'(TICK_CYCLES - 1));
	assign ms_tick = (ms_cnt_q == 24'(MS_TICKS - 1));

	// apb access strobes
	assign wr_en   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;
	assign w1c     = (wr_en && paddr == OFS_STAT) ? pwdata[ST_W-1:0] : '0;

	// settings, loaded with defaults at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q  <= CFG_RST;
			mask_q <= '0;
		end else if (wr_en) begin
			if (paddr == OFS_CTRL) begin
				{cfg_q.scale, cfg_q.spd_sel, cfg_q.slow_stop, cfg_q.slow_trim} <= pwdata[4:0];
			end else if (paddr == OFS_SLOW_A) begin
				cfg_q.slow[3:0] <= pwdata;
			end else if (paddr == OFS_SLOW_B) begin
				cfg_q.slow[4] <= pwdata[7:0];
			end else if (paddr == OFS_BND_A) begin
				cfg_q.bnd[3:0] <= {pwdata[30:24], pwdata[22:16], pwdata[14:8], pwdata[6:0]};
			end else if (paddr == OFS_BND_B) begin
				cfg_q.bnd[4] <= pwdata[6:0];
			end else if (paddr == OFS_PSPD_A) begin
				cfg_q.pspd[3:0] <= pwdata;
			end else if (paddr == OFS_PSPD_B) begin
				cfg_q.pspd[4] <= pwdata[7:0];
			end else if (paddr == OFS_LIMIT) begin
				cfg_q.max_rpm <= pwdata[7:0];
			end else if (paddr == OFS_TIMES) begin
				{cfg_q.ovl_t, cfg_q.sync_t} <= {pwdata[26:16], pwdata[10:0]};
			end else if (paddr == OFS_PWROFF) begin
				cfg_q.pwr <= pwdata[7:0];
			end else if (paddr == OFS_THR) begin
				{cfg_q.thr_rv, cfg_q.thr_rb, cfg_q.thr_ab} <= pwdata[23:0];
			end else if (paddr == OFS_SCALE) begin
				{cfg_q.updn, cfg_q.a2} <= pwdata[15:0];
			end else if (paddr == OFS_MASK) begin
				mask_q <= pwdata[ST_W-1:0];
			end
		end
	end

	// read mux, unmapped addresses answer with an error
	always_comb begin
		rd_d   = 32'h00000000;
		rd_err = 1'b0;
		if (paddr == OFS_CTRL) begin
			rd_d = {27'h0, cfg_q.scale, cfg_q.spd_sel, cfg_q.slow_stop, cfg_q.slow_trim};
		end else if (paddr == OFS_SLOW_A) begin
			rd_d = cfg_q.slow[3:0];
		end else if (paddr == OFS_SLOW_B) begin
			rd_d = {24'h0, cfg_q.slow[4]};
		end else if (paddr == OFS_BND_A) begin
			rd_d = {1'b0, cfg_q.bnd[3], 1'b0, cfg_q.bnd[2], 1'b0, cfg_q.bnd[1], 1'b0, cfg_q.bnd[0]};
		end else if (paddr == OFS_BND_B) begin
			rd_d = {25'h0, cfg_q.bnd[4]};
		end else if (paddr == OFS_PSPD_A) begin
			rd_d = cfg_q.pspd[3:0];
		end else if (paddr == OFS_PSPD_B) begin
			rd_d = {24'h0, cfg_q.pspd[4]};
		end else if (paddr == OFS_LIMIT) begin
			rd_d = {24'h0, cfg_q.max_rpm};
		end else if (paddr == OFS_TIMES) begin
			rd_d = {5'h0, cfg_q.ovl_t, 5'h0, cfg_q.sync_t};
		end else if (paddr == OFS_PWROFF) begin
			rd_d = {24'h0, cfg_q.pwr};
		end else if (paddr == OFS_THR) begin
			rd_d = {8'h0, cfg_q.thr_rv, cfg_q.thr_rb, cfg_q.thr_ab};
		end else if (paddr == OFS_SCALE) begin
			rd_d = {16'h0, cfg_q.updn, cfg_q.a2};
		end else if (paddr == OFS_STAT) begin
			rd_d = {25'h0, stat_q};
		end else if (paddr == OFS_MASK) begin
			rd_d = {25'h0, mask_q};
		end else if (paddr == OFS_RUNST) begin
			rd_d = {11'h0, state_q, idx_q, 2'h0, speed_cmd_q};
		end else begin
			rd_err = 1'b1;
		end
	end

	// answer captured in the setup cycle, shown in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q  <= pwrite ? 32'h00000000 : rd_d;
			pslverr_q <= rd_err;
		end
	end

	// encoder pattern checks
	assign ab_bad   = (pin_q.a != prev_q.a) && (pin_q.b != prev_q.b);
	assign sec_now  = hall_sec({pin_q.r, pin_q.s, pin_q.t});
	assign sec_prev = hall_sec({prev_q.r, prev_q.s, prev_q.t});
	assign rst_chg  = {pin_q.r, pin_q.s, pin_q.t} != {prev_q.r, prev_q.s, prev_q.t};
	assign rst_bad  = rst_chg && sec_now == 3'h7;
	assign rst_rev  = rst_chg && sec_now != 3'h7 && sec_prev != 3'h7 &&
		sec_now == ((sec_prev == 3'h0) ? 3'h5 : 3'(sec_prev - 3'h1));
	assign sync_rise = pin_q.sync && !prev_q.sync;

	sss_evt_cnt u_cnt_ab (.pclk(pclk), .presetn(presetn), .evt(ab_bad), .clr(w1c[ST_AB]),
		.thr(cfg_q.thr_ab), .hit(hit_ab));
	sss_evt_cnt u_cnt_rb (.pclk(pclk), .presetn(presetn), .evt(rst_bad), .clr(w1c[ST_RSTB]),
		.thr(cfg_q.thr_rb), .hit(hit_rb));
	sss_evt_cnt u_cnt_rv (.pclk(pclk), .presetn(presetn), .evt(rst_rev), .clr(w1c[ST_REV]),
		.thr(cfg_q.thr_rv), .hit(hit_rv));

	// watchdogs: synchronizer, overload, power loss
	sss_tmo u_tmo_sync (.pclk(pclk), .presetn(presetn), .en(speed_cmd_q != 14'h0000),
		.restart(sync_rise), .tick(tick), .limit(cfg_q.sync_t), .expired(sync_exp));
	sss_tmo u_tmo_ovl (.pclk(pclk), .presetn(presetn), .en(speed_cmd_q != 14'h0000 && motor_rpm < speed_cmd_q),
		.restart(cmd_d != speed_cmd_q), .tick(tick), .limit(cfg_q.ovl_t), .expired(ovl_exp));
	sss_tmo u_tmo_pwr (.pclk(pclk), .presetn(presetn), .en(!pin_q.sup_ok), .restart(1'b0),
		.tick(ms_tick), .limit({1'b0, cfg_q.pwr, 2'b00}), .expired(pwr_exp));

	// sticky status, a new event wins over a clear
	assign ev = {state_q == SS_SLOW && idx_q == 3'(LAST_STITCH) && sync_rise,
		hit_rv, hit_rb, hit_ab, pwr_exp, ovl_exp, sync_exp};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~w1c) | ev;
		end
	end
	assign fault = |stat_q[ST_REV:ST_SYNC];
	assign irq   = |(stat_q & mask_q);

	// slow start arming after trimming or after a stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_q <= 1'b0;
		end else if (state_q == SS_IDLE && step != 3'h0) begin
			armed_q <= 1'b0;
		end else if (trim_done && cfg_q.slow_trim) begin
			armed_q <= 1'b1;
		end else if (state_q == SS_RUN && step == 3'h0 && cfg_q.slow_stop) begin
			armed_q <= 1'b1;
		end
	end

	// run sequencer: slow stitches counted on synchronizer pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SS_IDLE;
			idx_q   <= 3'h0;
		end else begin
			case (state_q)
				SS_IDLE: begin
					idx_q <= 3'h0;
					if (step != 3'h0) begin
						state_q <= armed_q ? SS_SLOW : SS_RUN;
					end
				end
				SS_SLOW: begin
					if (step == 3'h0) begin
						state_q <= SS_IDLE;
					end else if (sync_rise && idx_q == 3'(LAST_STITCH)) begin
						state_q <= SS_RUN;
					end else if (sync_rise) begin
						idx_q <= 3'(idx_q + 3'h1);
					end
				end
				SS_RUN: begin
					if (step == 3'h0) begin
						state_q <= SS_IDLE;
					end
				end
				default: state_q <= SS_IDLE;
			endcase
		end
	end

	// pedal curve and slow stitch speed selection
	assign step       = fwd_step(pedal_level[9:4], cfg_q.bnd);
	assign pedal_code = (step == 3'h0) ? 8'h00 : cfg_q.pspd[3'(step - 3'h1)];
	assign slow_code  = cfg_q.spd_sel ? cfg_q.slow[idx_q] : BUILTIN_SLOW[idx_q];
	always_comb begin
		case (cfg_q.scale)
			2'h0: curve_code = pedal_code;
			2'h1: curve_code = scale(pedal_code, cfg_q.a2, cfg_q.pspd[4]);
			2'h2: curve_code = scale(pedal_code, cfg_q.updn, cfg_q.pspd[4]);
			default: curve_code = pedal_code;
		endcase
		code  = (state_q == SS_SLOW) ? slow_code : (state_q == SS_RUN) ? curve_code : 8'h00;
		cmd_d = (fault || step == 3'h0) ? 14'h0000 : clamp_cmd(code, cfg_q.max_rpm);
	end

	// registered motor command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_cmd_q <= 14'h0000;
		end else begin
			speed_cmd_q <= cmd_d;
		end
	end
	assign speed_cmd   = speed_cmd_q;
	assign slow_active = (state_q == SS_SLOW);

	cmd_ceiling_a: assert property (@(posedge pclk) disable iff (!presetn)
		speed_cmd_q <= 14'($past(cfg_q.max_rpm)) * 14'(RPM_STEP)) else $error("command above ceiling");
	slow_first_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SS_SLOW && idx_q == 3'h0 && cfg_q.spd_sel && !fault && step != 3'h0
		|=> speed_cmd_q == clamp_cmd($past(cfg_q.slow[0]), $past(cfg_q.max_rpm))) else $error("first stitch speed wrong");
	slow_builtin_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SS_SLOW && idx_q == 3'h2 && !cfg_q.spd_sel && !fault && step != 3'h0
		|=> speed_cmd_q == clamp_cmd(BUILTIN_SLOW[2], $past(cfg_q.max_rpm))) else $error("built-in slow speed wrong");
	slow_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SS_SLOW && idx_q == 3'(LAST_STITCH) && sync_rise && step != 3'h0
		|=> state_q == SS_RUN && stat_q[ST_SLOW]) else $error("slow start did not hand over");
	trim_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
		trim_done && cfg_q.slow_trim && !(state_q == SS_IDLE && step != 3'h0) |=> armed_q) else $error("slow start not armed");
	pedal_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		step == 3'h0 |=> speed_cmd_q == 14'h0000) else $error("motor driven with pedal released");
	mode0_curve_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == SS_RUN && cfg_q.scale == 2'h0 && !fault && step != 3'h0
		|=> speed_cmd_q == clamp_cmd($past(pedal_code), $past(cfg_q.max_rpm))) else $error("mode 0 curve wrong");
	sync_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stat_q[ST_SYNC]) |-> $past(sync_exp) && $past(tick)) else $error("sync error without timeout");
	ovl_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		ovl_exp |=> stat_q[ST_OVL] ##1 speed_cmd_q == 14'h0000) else $error("overload not acted on");
	pwr_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwr_exp |-> !pin_q.sup_ok ##1 stat_q[ST_PWR]) else $error("power loss not flagged");
	rev_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		hit_rv |=> stat_q[ST_REV]) else $error("reverse fault not flagged");
	rst_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		hit_rb |=> stat_q[ST_RSTB]) else $error("commutation fault not flagged");
	slow_seq_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(stat_q[ST_SLOW]));
	sync_err_c: cover property (@(posedge pclk) disable iff (!presetn) sync_exp);
	ovl_err_c: cover property (@(posedge pclk) disable iff (!presetn) ovl_exp);
	enc_err_c: cover property (@(posedge pclk) disable iff (!presetn) hit_ab);
endmodule : sss_supervisor

//--- sss_motor_model.sv
// sss_motor_model: servo motor with encoder and synchronizer sensor
module sss_motor_model
	import sss_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [13:0] speed_cmd,
	input  wire logic [2:0]  fault,
	output sss_pins_s        pins,
	output logic [13:0]      motor_rpm
);
	logic [3:0] ph_q;
	// shaft phase turns only while commanded and stays where it stopped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q <= 4'h0;
		end else if (speed_cmd != 14'h0) begin
			ph_q <= ph_q + 4'h1;
		end
	end
	// fault 1: sync stuck, 2: stall, 3: supply lost, 4: a/b jump, 5: bad r/s/t, 6: reverse r/s/t
	assign pins.sync   = ph_q[3] && fault != 3'h1;
	assign pins.sup_ok = fault != 3'h3;
	assign pins.a      = (fault == 3'h4) ? ph_q[0] : ph_q[1];
	assign pins.b      = (fault == 3'h4) ? ph_q[0] : ph_q[1] ^ ph_q[0];
	assign {pins.r, pins.s, pins.t} = (fault == 3'h5) ? {2'b00, !ph_q[0]} :
		(fault == 3'h6) ? {ph_q[0], 2'b01} : 3'b001;
	assign motor_rpm   = (fault == 3'h2) ? 14'h0 : speed_cmd;
endmodule : sss_motor_model

//--- tb_top.sv
// tb_top: self-checking bench of the servo speed supervisor
module tb_top
	import sss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, trim_done, slow_active, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0]  pedal_level;
	logic [13:0] motor_rpm, speed_cmd;
	logic [2:0]  fault;
	sss_pins_s   pins;
	int          n_mismatch, tests_run, n;

	sss_supervisor #(.TICK_CYCLES(20), .MS_TICKS(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pedal_level(pedal_level), .trim_done(trim_done), .motor_rpm(motor_rpm),
		.pins(pins), .speed_cmd(speed_cmd), .slow_active(slow_active), .irq(irq));
	sss_motor_model motor (.pclk(pclk), .presetn(presetn), .speed_cmd(speed_cmd), .fault(fault),
		.pins(pins), .motor_rpm(motor_rpm));

	// clock 100 MHz
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask : cyc

	// one apb transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, ee});
	endtask : rdc

	task automatic ped(input logic [5:0] q, input logic [13:0] e);
		pedal_level <= {q, 4'h0};
		cyc(4);
		chk({18'h0, speed_cmd}, {18'h0, e});
	endtask : ped

	task automatic t_reset();
		rdc(OFS_CTRL, 32'h8, 1'b0);
		rdc(OFS_SLOW_A, 32'h19100A0A, 1'b0);
		rdc(OFS_LIMIT, 32'hC8, 1'b0);
		rdc(OFS_TIMES, 32'h001E0028, 1'b0);
		rdc(OFS_PWROFF, 32'h1, 1'b0);
		rdc(OFS_THR, 32'h00040404, 1'b0);
		rdc(OFS_STAT, 32'h0, 1'b0);
		rdc(12'hFFC, 32'h0, 1'b1);
		$display("reset test done");
	endtask : t_reset

	task automatic t_pedal();
		wr(OFS_CTRL, 32'h0);
		ped(6'd16, 14'd0);
		ped(6'd17, 14'd440);
		ped(6'd63, 14'd4000);
		wr(OFS_LIMIT, 32'd10);
		ped(6'd17, 14'd200);
		wr(OFS_LIMIT, 32'd250);
		ped(6'd63, 14'd5000);
		wr(OFS_CTRL, 32'h8);
		ped(6'd63, 14'd4000);
		wr(OFS_SCALE, 32'h3264);
		wr(OFS_CTRL, 32'h10);
		ped(6'd63, 14'd2000);
		ped(6'd0, 14'd0);
		$display("pedal test done");
	endtask : t_pedal

	task automatic t_slow();
		wr(OFS_SLOW_A, 32'h19100A07);
		for (int s = 0; s < 2; s++) begin
			wr(OFS_CTRL, s ? 32'h5 : 32'h1);
			trim_done <= 1'b1;
			cyc(1);
			trim_done <= 1'b0;
			pedal_level <= 10'h3F0;
			cyc(3);
			chk({31'h0, slow_active}, 32'h1);
			chk({18'h0, speed_cmd}, s ? 32'd280 : 32'd400);
			n = 0;
			while (slow_active !== 1'b0 && n < 400) begin cyc(1); n++; end
			rdc(OFS_STAT, 32'h40, 1'b0);
			chk({18'h0, speed_cmd}, 32'd5000);
			wr(OFS_STAT, 32'h40);
			ped(6'd0, 14'd0);
		end
		$display("slow start test done");
	endtask : t_slow

	// sync loss, overload, supply loss and encoder faults each latch their status bit
	task automatic t_wd();
		logic [31:0] tv [6] = '{32'h5, 32'h00050028, 32'h001E0028,
			32'h001E0028, 32'h001E0028, 32'h001E0028};
		int lo [6] = '{80, 80, 30, 4, 4, 4};
		for (int i = 0; i < 6; i++) begin
			wr(OFS_TIMES, tv[i]);
			wr(OFS_MASK, 32'h1 << i);
			fault <= 3'(i + 1);
			pedal_level <= 10'h3F0;
			n = 0;
			while (irq !== 1'b1 && n < 400) begin cyc(1); n++; end
			chk(32'(n >= lo[i] && n <= lo[i] + 60), 32'h1);
			rdc(OFS_STAT, 32'h1 << i, 1'b0);
			chk({18'h0, speed_cmd}, 32'h0);
			fault <= 3'h0;
			ped(6'd0, 14'd0);
			wr(OFS_STAT, 32'h1 << i);
			cyc(2);
			chk({31'h0, irq}, 32'h0);
		end
		$display("watchdog test done");
	endtask : t_wd

	// hang guard
	initial begin
		cyc(20000);
		n_mismatch++;
		conclude();
	end

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
		pedal_level = 10'h0; trim_done = 1'b0; fault = 3'h0; n_mismatch = 0; tests_run = 0;
		cyc(12);
		presetn <= 1'b1;
		t_reset();
		t_pedal();
		t_slow();
		t_wd();
		conclude();
	end
endmodule : tb_top
